// ===== hdl/aoc_ctrl.sv
`timescale 1ns/10ps
`include "aoc_params.svh"

// Overview of operation
// - The divider takes factors 2 to 128 and reads back the factor in force.
// - An odd factor n gives a divided clock high for (n+1)/2 bit periods and low for (n-1)/2.
// - The output works in exactly one of four roles and the selected role reads back.
// - The second stream may be shifted by minus one, zero or plus one bit, and the shift reads back.
// - The shift is applied only in the de-emphasis role.
// - The internal pattern control source turns second channel blanking off.
// - The blanking pattern control source turns blanking on in every role except the sub-clock role, and the active source reads back.
// - A tripped protection reads on and disables the output so no signal leaves.
// - A protection reset clears the trip and returns the output to normal operation.
// - With electrical idle enabled, the external signal on the idle input gates the stream into idle.
// - With electrical idle enabled, error insertion is inhibited.
// - Selecting the user-defined level family is ignored and changes nothing.
// - The family reads as user-defined once any voltage parameter was written, even back to default.
// - DC coupling enables the termination source, AC disables it, and the choice reads back.
// - The crossover setting accepts changes only in NRZ format and refuses them otherwise.
module aoc_ctrl (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic nrz_fmt,
  input wire logic err_insert,
  input wire logic ext_idle_pin,
  input wire logic prot_trip_pin,
  input wire logic src_valid,
  input wire logic src_main,
  input wire logic src_alt,
  output logic src_ready,
  output logic aux_valid,
  output logic aux_bit,
  input wire logic aux_ready,
  output logic sub_clk,
  output logic aux_out_en,
  output logic aux_idle,
  output logic term_src_en
);

  aoc_pkg::aoc_state_t s_q;
  aoc_pkg::aoc_state_t s_d;

  aoc_stream_if fill_if ();
  aoc_stream_if drain_if ();

  // High time of the divided clock; (n+1)/2 covers both odd and even n.
  function automatic logic [6:0] high_len(input logic [7:0] n);
    logic [8:0] sum;
    sum = {1'b0, n} + 9'h001;
    high_len = sum[7:1];
  endfunction

  // Refusal decision for a write, taken in the first access cycle.
  function automatic logic wr_refused(input logic [7:0] a, input logic [31:0] w, input logic nrz);
    wr_refused = 1'b0;
    unique case (a)
      `AOC_ADDR_CTRL: wr_refused = w[`AOC_CTRL_OFFS] == `AOC_OFFS_BAD;
      `AOC_ADDR_DIV: wr_refused = w[7:0] < `AOC_DIV_MIN || w[7:0] > `AOC_DIV_MAX;
      `AOC_ADDR_LEVEL: wr_refused = w[2:0] > `AOC_FAM_USER;
      `AOC_ADDR_EYE_CROSSING_POINT: wr_refused = !nrz;
      `AOC_ADDR_VOLT, `AOC_ADDR_STATUS: wr_refused = 1'b0;
      default: wr_refused = 1'b1;
    endcase
  endfunction

  always_comb begin
    logic access;
    logic push;
    logic b;
    logic [7:0] last;
    logic [6:0] cnt_n;
    access = psel & penable;
    push = src_valid & fill_if.ready;
    b = 1'b0;
    last = s_q.div - 8'h01;
    cnt_n = s_q.cnt;
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.trip_s = {s_q.trip_s[0], prot_trip_pin};
    s_d.idle_s = {s_q.idle_s[0], ext_idle_pin};

    // One wait state: the answer is prepared in the first access cycle.
    if (access && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      if (pwrite) begin
        s_d.pslverr = wr_refused(paddr, pwdata, nrz_fmt);
      end else begin
        unique case (paddr)
          `AOC_ADDR_CTRL: s_d.prdata[6:0] = {s_q.dc, s_q.idle_en, s_q.blank, s_q.offs, s_q.role};
          `AOC_ADDR_DIV: s_d.prdata[7:0] = s_q.div;
          `AOC_ADDR_LEVEL: s_d.prdata[2:0] = s_q.modified ? `AOC_FAM_USER : s_q.family;
          `AOC_ADDR_VOLT: s_d.prdata[15:0] = s_q.volt;
          `AOC_ADDR_EYE_CROSSING_POINT: s_d.prdata[7:0] = s_q.eye_crossing_point;
          `AOC_ADDR_STATUS: s_d.prdata[1:0] = {s_q.idle_out, s_q.tripped};
          default: s_d.pslverr = 1'b1;
        endcase
      end
    end

    // A write takes effect at the edge where pready is seen high.
    if (access && s_q.pready && pwrite && !s_q.pslverr) begin
      unique case (paddr)
        `AOC_ADDR_CTRL: begin
          s_d.role = aoc_pkg::aoc_role_t'(pwdata[`AOC_CTRL_ROLE]);
          s_d.offs = pwdata[`AOC_CTRL_OFFS];
          s_d.blank = pwdata[`AOC_CTRL_BLANK];
          s_d.idle_en = pwdata[`AOC_CTRL_IDLE];
          s_d.dc = pwdata[`AOC_CTRL_DC];
        end
        `AOC_ADDR_DIV: begin
          s_d.div = pwdata[7:0];
          s_d.cnt = 7'h00;
        end
        `AOC_ADDR_LEVEL: begin
          // The user-defined code is accepted on the bus but has no effect.
          if (pwdata[2:0] != `AOC_FAM_USER) begin
            s_d.family = pwdata[2:0];
            s_d.modified = 1'b0;
          end
        end
        `AOC_ADDR_VOLT: begin
          s_d.volt = pwdata[15:0];
          s_d.modified = 1'b1;
        end
        `AOC_ADDR_EYE_CROSSING_POINT: s_d.eye_crossing_point = pwdata[7:0];
        `AOC_ADDR_STATUS: begin
          if (pwdata[`AOC_STAT_TRIP]) begin
            s_d.tripped = 1'b0;
          end
        end
        default: s_d.tripped = s_d.tripped;
      endcase
    end

    // A trip seen in the same cycle as a reset write wins.
    if (s_q.trip_s[1]) begin
      s_d.tripped = 1'b1;
    end

    // Stream path: one accepted source word is one bit period.
    unique case (s_q.role)
      aoc_pkg::AOC_ROLE_SUBCLK: b = s_q.sub_clk;
      aoc_pkg::AOC_ROLE_SECOND: b = s_q.alt;
      aoc_pkg::AOC_ROLE_MUX: b = s_q.mux_sel ? s_q.alt : s_q.hist[0];
      aoc_pkg::AOC_ROLE_TAP: begin
        // The zero shift uses a one-bit delay so that both directions exist.
        unique case (s_q.offs)
          `AOC_OFFS_PLUS: b = src_main;
          `AOC_OFFS_MINUS: b = s_q.hist[1];
          default: b = s_q.hist[0];
        endcase
      end
    endcase
    if (s_q.blank && s_q.role != aoc_pkg::AOC_ROLE_SUBCLK) begin
      b = 1'b0;
    end
    if (push) begin
      s_d.hist = {s_q.hist[0], src_main};
      s_d.alt = src_alt;
      s_d.mux_sel = !s_q.mux_sel;
      cnt_n = ({1'b0, s_q.cnt} >= last) ? 7'h00 : s_q.cnt + 7'h01;
      s_d.cnt = cnt_n;
      s_d.sub_clk = cnt_n < high_len(s_q.div);
      if (s_q.err_pend && !s_q.idle_en) begin
        b = !b;
      end
      s_d.err_pend = 1'b0;
    end
    if (s_q.idle_en) begin
      s_d.err_pend = 1'b0;
    end
    if (err_insert && !s_q.idle_en) begin
      s_d.err_pend = 1'b1;
    end
    s_d.idle_out = s_q.idle_en & s_q.idle_s[1];
    if (s_q.idle_out || s_q.tripped) begin
      b = 1'b0;
    end
    s_d.aux_en = !s_d.tripped;
    s_d.term_en = s_d.dc;
    fill_if.valid = src_valid;
    fill_if.data = b;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.div <= `AOC_DIV_RST;
      s_q.sub_clk <= 1'b1;
      s_q.family <= `AOC_FAM_RST;
      s_q.volt <= `AOC_VOLT_RST;
      s_q.eye_crossing_point <= `AOC_EYE_CROSSING_POINT_RST;
      s_q.aux_en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  aoc_skid_buf u_buf (
    .clock(clock),
    .rst(rst),
    .fill(fill_if),
    .drain(drain_if)
  );

  assign drain_if.ready = aux_ready;
  assign src_ready = fill_if.ready;
  assign aux_valid = drain_if.valid;
  assign aux_bit = drain_if.data;
  assign pready = s_q.pready;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign sub_clk = s_q.sub_clk;
  assign aux_out_en = s_q.aux_en;
  assign aux_idle = s_q.idle_out;
  assign term_src_en = s_q.term_en;

endmodule

// ===== hdl/aoc_params.svh
`ifndef AOC_PARAMS_SVH
`define AOC_PARAMS_SVH

// Register byte addresses.
`define AOC_ADDR_CTRL 8'h00
`define AOC_ADDR_DIV 8'h04
`define AOC_ADDR_LEVEL 8'h08
`define AOC_ADDR_VOLT 8'h0C
`define AOC_ADDR_EYE_CROSSING_POINT 8'h10
`define AOC_ADDR_STATUS 8'h14

// Control register fields.
`define AOC_CTRL_ROLE 1:0
`define AOC_CTRL_OFFS 3:2
`define AOC_CTRL_BLANK 4
`define AOC_CTRL_IDLE 5
`define AOC_CTRL_DC 6

// Bit shift encodings.
`define AOC_OFFS_ZERO 2'h0
`define AOC_OFFS_PLUS 2'h1
`define AOC_OFFS_MINUS 2'h2
`define AOC_OFFS_BAD 2'h3

// Status fields; writing one to the trip bit resets the protection.
`define AOC_STAT_TRIP 0
`define AOC_STAT_IDLE 1

// Divider limits and reset value.
`define AOC_DIV_MIN 8'h02
`define AOC_DIV_MAX 8'h80
`define AOC_DIV_RST 8'h02

// Logic families; codes above the user-defined one are refused.
`define AOC_FAM_RST 3'h0
`define AOC_FAM_MAX 3'h4
`define AOC_FAM_USER 3'h5

`define AOC_VOLT_RST 16'h0000
`define AOC_EYE_CROSSING_POINT_RST 8'h32

`endif

// ===== hdl/aoc_pkg.sv
package aoc_pkg;

  typedef enum logic [1:0] {
    AOC_ROLE_SUBCLK = 2'b00,
    AOC_ROLE_SECOND = 2'b01,
    AOC_ROLE_MUX = 2'b10,
    AOC_ROLE_TAP = 2'b11
  } aoc_role_t;

  typedef struct packed {
    logic d0;
    logic d1;
    logic [1:0] cnt;
    logic vld;
    logic rdy;
  } aoc_buf_t;

  typedef struct packed {
    aoc_role_t role;
    logic [1:0] offs;
    logic blank;
    logic idle_en;
    logic dc;
    logic [7:0] div;
    logic [6:0] cnt;
    logic sub_clk;
    logic [2:0] family;
    logic modified;
    logic [15:0] volt;
    logic [7:0] eye_crossing_point;
    logic tripped;
    logic err_pend;
    logic [1:0] hist;
    logic alt;
    logic mux_sel;
    logic [1:0] trip_s;
    logic [1:0] idle_s;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic aux_en;
    logic idle_out;
    logic term_en;
  } aoc_state_t;

endpackage

// ===== hdl/aoc_skid_buf.sv
`timescale 1ns/10ps
// Two-entry buffer; all outputs come from flip-flops, so a stall on the
// drain side reaches the filler one cycle later without losing a bit.
module aoc_skid_buf (
  input wire logic clock,
  input wire logic rst,
  aoc_stream_if.snk fill,
  aoc_stream_if.src drain
);

  aoc_pkg::aoc_buf_t s_q;
  aoc_pkg::aoc_buf_t s_d;

  always_comb begin
    logic push;
    logic pop;
    logic [1:0] cnt;
    push = fill.valid & s_q.rdy;
    pop = s_q.vld & drain.ready;
    s_d = s_q;
    cnt = s_q.cnt;
    if (pop) begin
      s_d.d0 = s_q.d1;
      cnt = cnt - 2'h1;
    end
    if (push) begin
      if (cnt == 2'h0) begin
        s_d.d0 = fill.data;
      end else begin
        s_d.d1 = fill.data;
      end
      cnt = cnt + 2'h1;
    end
    s_d.cnt = cnt;
    s_d.vld = cnt != 2'h0;
    s_d.rdy = cnt != 2'h2;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '{d0: 1'b0, d1: 1'b0, cnt: 2'h0, vld: 1'b0, rdy: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign fill.ready = s_q.rdy;
  assign drain.valid = s_q.vld;
  assign drain.data = s_q.d0;

endmodule

// ===== hdl/aoc_stream_if.sv
`timescale 1ns/10ps
interface aoc_stream_if;
  logic valid;
  logic ready;
  logic data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== sim/aoc_ctrl_props.sv
`timescale 1ns/10ps
`include "aoc_params.svh"
module aoc_ctrl_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic nrz_fmt,
  input wire logic prot_trip_pin,
  input wire logic src_ready,
  input wire logic aux_valid,
  input wire logic aux_bit,
  input wire logic aux_ready,
  input wire logic aux_out_en,
  input wire logic term_src_en
);
  logic ctrl_wr;
  assign ctrl_wr = pready && pwrite && paddr == `AOC_ADDR_CTRL;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  ans_wait_a: assert property (acc_s |=> pready) else $error("no answer after access cycle");
  ans_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  ans_cause_a: assert property (pready |-> $past(psel && penable)) else $error("ready without access");
  err_qual_a: assert property (pslverr |-> pready) else $error("error without ready");
  div_refuse_a: assert property (acc_s ##0 (pwrite && paddr == `AOC_ADDR_DIV &&
    (pwdata < 32'h00000002 || pwdata > 32'h00000080)) |=> pslverr) else $error("bad divider accepted");
  xov_refuse_a: assert property (acc_s ##0 (pwrite && paddr == `AOC_ADDR_EYE_CROSSING_POINT && !nrz_fmt)
    |=> pslverr) else $error("crossover changed outside NRZ");
  trip_cut_a: assert property (prot_trip_pin [*4] |-> ##[1:2] !aux_out_en) else $error("trip kept output on");
  aux_hold_a: assert property (aux_valid && !aux_ready |=> aux_valid && $stable(aux_bit)) else $error("stalled bit lost");
  src_full_a: assert property (!src_ready |-> aux_valid) else $error("refusing while empty");
  coup_cause_a: assert property ($changed(term_src_en) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("termination changed without write");
endmodule
bind aoc_ctrl aoc_ctrl_props u_props (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .nrz_fmt, .prot_trip_pin, .src_ready, .aux_valid, .aux_bit, .aux_ready, .aux_out_en, .term_src_en);

// ===== sim/aoc_sink.sv
`timescale 1ns/10ps
// Receiver of the output stream; in slow mode it accepts one bit in four.
module aoc_sink (
  input wire logic clock,
  input wire logic slow,
  input wire logic aux_valid,
  input wire logic aux_bit,
  output logic aux_ready
);
  logic [1:0] ph = 2'h0;
  logic rx[$];
  initial aux_ready = 1'b1;
  always @(posedge clock) begin
    ph <= ph + 2'h1;
    if (aux_valid === 1'b1 && aux_ready) rx.push_back(aux_bit);
    aux_ready <= !slow || ph == 2'h3;
  end
endmodule

// ===== sim/testbench.sv
`timescale 1ns/10ps
`include "aoc_params.svh"
module testbench;
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nrz_fmt = 1'b0, slow = 1'b0;
  logic err_insert = 1'b0, ext_idle_pin = 1'b0, prot_trip_pin = 1'b0, src_valid = 1'b0, src_main = 1'b0;
  logic src_alt = 1'b0, pready, pslverr, src_ready, aux_valid, aux_bit, aux_ready, sub_clk, aux_out_en;
  logic aux_idle, term_src_en, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [15:0] mp = 16'hB38E, ap = 16'h6A5C;
  int errors = 0, comparisons = 0, hi;
  aoc_ctrl DUT (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .nrz_fmt,
    .err_insert, .ext_idle_pin, .prot_trip_pin, .src_valid, .src_main, .src_alt, .src_ready, .aux_valid,
    .aux_bit, .aux_ready, .sub_clk, .aux_out_en, .aux_idle, .term_src_en);
  aoc_sink sink (.clock, .slow, .aux_valid, .aux_bit, .aux_ready);
  initial forever #25 clock = ~clock;
  task results;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      results;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Pushes n words and counts the words after which the divided clock is high.
  // The divided clock is read at the edge after each push, where the pushed step stands.
  task sendw(input int n);
    int i, k;
    logic pend;
    i = 0; k = 0; hi = 0; pend = 1'b0;
    sink.rx.delete();
    src_valid <= 1'b1; src_main <= mp[0]; src_alt <= ap[0];
    while ((i < n || pend) && k < 3000) begin
      @(posedge clock);
      k++;
      if (pend) hi += (sub_clk === 1'b1);
      pend = i < n && src_ready === 1'b1;
      if (pend) begin
        i++;
        src_valid <= i < n; src_main <= mp[i % 16]; src_alt <= ap[i % 16];
      end
    end
    repeat (2) @(posedge clock);
    while (aux_valid !== 1'b0 && k < 3000) begin
      @(posedge clock);
      k++;
    end
    if (k >= 3000) begin
      errors++;
      results;
    end
  endtask
  // Expected bit i is zero, or main or alternate bit of word i-d.
  task stream_case(input logic [31:0] c, input int d, input logic alt, input logic zero);
    apb(1'b1, `AOC_ADDR_CTRL, c);
    sendw(16);
    chk(sink.rx.size(), 16);
    // The run before each case sends a multiple of 16 words, so the words before word 0 are those of the pattern's end.
    for (int i = 0; i < 16 && i < sink.rx.size(); i++)
      chk(sink.rx[i], zero ? 1'b0 : alt ? ap[(i - d + 16) % 16] : mp[(i - d + 16) % 16]);
  endtask
  task t_regs;
    apb(1'b0, `AOC_ADDR_CTRL, 0); chk(rd, 0);
    apb(1'b0, `AOC_ADDR_DIV, 0); chk(rd, `AOC_DIV_RST);
    apb(1'b0, `AOC_ADDR_EYE_CROSSING_POINT, 0); chk(rd, `AOC_EYE_CROSSING_POINT_RST);
    chk({sub_clk, term_src_en}, 2'h2);
    apb(1'b0, 8'h20, 0); chk({err, rd}, 33'h100000000);
    apb(1'b1, `AOC_ADDR_LEVEL, 2); apb(1'b1, `AOC_ADDR_LEVEL, 5); chk(err, 0);
    apb(1'b0, `AOC_ADDR_LEVEL, 0); chk(rd, 2);
    apb(1'b1, `AOC_ADDR_LEVEL, 6); chk(err, 1);
    apb(1'b1, `AOC_ADDR_VOLT, `AOC_VOLT_RST); apb(1'b0, `AOC_ADDR_LEVEL, 0); chk(rd, `AOC_FAM_USER);
    apb(1'b1, `AOC_ADDR_EYE_CROSSING_POINT, 32'h40); chk(err, 1);
    apb(1'b0, `AOC_ADDR_EYE_CROSSING_POINT, 0); chk(rd, `AOC_EYE_CROSSING_POINT_RST);
    nrz_fmt <= 1'b1;
    apb(1'b1, `AOC_ADDR_EYE_CROSSING_POINT, 32'h40); apb(1'b0, `AOC_ADDR_EYE_CROSSING_POINT, 0); chk({err, rd}, 33'h40);
  endtask
  task t_ctrl;
    for (int c = 0; c < 12; c++) begin
      apb(1'b1, `AOC_ADDR_CTRL, c); apb(1'b0, `AOC_ADDR_CTRL, 0); chk(rd, c);
    end
    apb(1'b1, `AOC_ADDR_CTRL, 32'h0C); chk(err, 1);
    apb(1'b0, `AOC_ADDR_CTRL, 0); chk({err, rd}, 33'h0B);
    apb(1'b1, `AOC_ADDR_CTRL, 32'h40); @(posedge clock); chk(term_src_en, 1);
    apb(1'b1, `AOC_ADDR_CTRL, 0); @(posedge clock); chk(term_src_en, 0);
  endtask
  task t_div;
    int f[4] = '{3, 4, 7, 128};
    foreach (f[j]) begin
      apb(1'b1, `AOC_ADDR_DIV, f[j]); sendw(2 * f[j]); chk(hi, 2 * ((f[j] + 1) / 2));
    end
    apb(1'b1, `AOC_ADDR_DIV, 1); chk(err, 1);
    apb(1'b1, `AOC_ADDR_DIV, 129); chk(err, 1);
    apb(1'b0, `AOC_ADDR_DIV, 0); chk({err, rd}, 33'h80);
  endtask
  task t_stream;
    stream_case(32'h05, 1, 1'b1, 1'b0);
    stream_case(32'h07, 0, 1'b0, 1'b0);
    slow <= 1'b1;
    stream_case(32'h03, 1, 1'b0, 1'b0);
    slow <= 1'b0;
    stream_case(32'h0B, 2, 1'b0, 1'b0);
    stream_case(32'h11, 1, 1'b1, 1'b1);
    stream_case(32'h01, 1, 1'b1, 1'b0);
    // The word count since reset is even here, so the first word takes the main path.
    apb(1'b1, `AOC_ADDR_CTRL, 32'h02);
    sendw(16);
    for (int i = 0; i < 16; i++) chk(sink.rx[i], i % 2 ? ap[(i + 15) % 16] : mp[(i + 15) % 16]);
    err_insert <= 1'b1;
    @(posedge clock);
    err_insert <= 1'b0;
    apb(1'b1, `AOC_ADDR_CTRL, 32'h05);
    sendw(16);
    chk(sink.rx[0], !ap[15]);
    chk(sink.rx[1], ap[0]);
    apb(1'b1, `AOC_ADDR_CTRL, 32'h25);
    err_insert <= 1'b1;
    @(posedge clock);
    err_insert <= 1'b0;
    stream_case(32'h25, 1, 1'b1, 1'b0);
  endtask
  task t_idle_prot;
    ext_idle_pin <= 1'b1;
    repeat (4) @(posedge clock);
    apb(1'b0, `AOC_ADDR_STATUS, 0); chk({aux_idle, rd[1]}, 2'h3);
    stream_case(32'h25, 1, 1'b1, 1'b1);
    ext_idle_pin <= 1'b0;
    repeat (4) @(posedge clock);
    chk(aux_idle, 0);
    prot_trip_pin <= 1'b1;
    repeat (5) @(posedge clock);
    apb(1'b0, `AOC_ADDR_STATUS, 0); chk({aux_out_en, rd[0]}, 2'h1);
    stream_case(32'h05, 1, 1'b1, 1'b1);
    prot_trip_pin <= 1'b0;
    repeat (4) @(posedge clock);
    apb(1'b1, `AOC_ADDR_STATUS, 1); apb(1'b0, `AOC_ADDR_STATUS, 0); chk({aux_out_en, rd[0]}, 2'h2);
    stream_case(32'h05, 1, 1'b1, 1'b0);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_regs;
    t_ctrl;
    t_div;
    t_stream;
    t_idle_prot;
    results;
  end
endmodule
